// [logic/disk_sector_header_check.v]
// Sector header build, compare and CRC check of a moving-head disk drive
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "disk_hdr_map.vh"
// Summary of operation
// [R01] Drive registers of 16 bits, one per word
// [R02] Shared register: drive makes bits 12,11,4:0
// [R03] Controller loads and reads registers over host port
// [R04] Track holds 22 sectors, header then data
// [R05] First sector after index is sector zero
// [R06] Short data padded with zeros to 256 words
// [R07] Header is five consecutive 16-bit words
// [R08] Word one carries 9-bit cylinder address
// [R09] Word one bit 12 is format-mode flag
// [R10] Word two low five bits: sector
// [R11] Word two upper byte low bits: track
// [R12] Key words passed through uninterpreted
// [R13] Word five CRC generated, checked, never exposed
// [R14] Compare first two words, then check CRC
// [R15] Header faults set format, compare, CRC bits
// [R16] Errors valid only after sector lookahead match
// [R17] Read-header-and-data function moves header to memory
// [R18] Software formats and verifies pack before use
// [R19] CRC polynomial and seed are build constants
module disk_sector_header_check
(
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Medium side
	input wire index_i,
	input wire sector_i,
	input wire word_tick_i,
	input wire [15:0] rd_word_i,
	output reg [15:0] wr_word_o,
	output reg wr_gate_o,
	// Data to and from memory
	input wire [15:0] data_i,
	input wire data_valid_i,
	output reg data_take_o,
	output reg [15:0] xfer_word_o,
	output reg xfer_valid_o,
	// Interrupt
	output reg irq_o
);

localparam S_IDLE = 2'h0;
localparam S_SEEK = 2'h1;
localparam S_HDR = 2'h2;
localparam S_DATA = 2'h3;

// ------------------------------------------------------------
// Helpers
// ------------------------------------------------------------
function [15:0] crc_step;
	input [15:0] c;
	input [15:0] d;
	integer i;
	reg [15:0] x;
	begin
		x = c;
		for (i = 15; i >= 0; i = i - 1)
		begin
			if (x[15] ^ d[i])
				x = {x[14:0], 1'b0} ^ `CRC_POLY;
			else
				x = {x[14:0], 1'b0};
		end
		crc_step = x;
	end
endfunction

function [15:0] merge16;
	input [15:0] old;
	input [15:0] nw;
	input [1:0] sel;
	begin
		merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
	end
endfunction

// ------------------------------------------------------------
// State
// ------------------------------------------------------------
reg [1:0] state_r;
reg [2:0] fn_r;
reg [8:0] cnt_r;
reg [15:0] crc_r;
reg hdr_err_r;
reg short_r;
reg [4:0] sec_cnt_r;
reg [8:0] des_cyl_r;
reg des_fmt_r;
reg [4:0] des_trk_r;
reg [4:0] des_sec_r;
reg [15:0] key1_r;
reg [15:0] key2_r;
reg [3:0] stat_r;
reg [3:0] mask_r;

wire [3:0] idx = wb_adr_i[5:2];
wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire bus_wr = bus_req & wb_we_i;
wire [15:0] wdat = wb_dat_i[15:0];
wire busy = (state_r != S_IDLE);
wire sector_start = index_i | sector_i;
wire is_fmt = (fn_r == `FN_FORMAT);
wire is_wr = is_fmt | (fn_r == `FN_WRITE);

// ------------------------------------------------------------
// Sector counter
// ------------------------------------------------------------
reg [4:0] sec_nxt;
always @*
begin
	// [R05] index restarts count
	if (index_i)
		sec_nxt = 5'h00;
	// [R04] wraps after 22 sectors
	else if (sec_cnt_r == `LAST_SECTOR)
		sec_nxt = 5'h00;
	else
		sec_nxt = sec_cnt_r + 5'h01;
end

always @(posedge clk_i)
begin
	if (rst_i)
		sec_cnt_r <= 5'h00;
	else if (sector_start)
		sec_cnt_r <= sec_nxt;
end

// ------------------------------------------------------------
// Header word build and compare
// ------------------------------------------------------------
reg [15:0] built;
always @*
begin
	case (cnt_r)
		// [R08] cylinder field
		// [R09] format-mode bit
		9'h000: built = {3'h0, des_fmt_r, 3'h0, des_cyl_r};
		// [R10] sector in low bits
		// [R11] track in upper byte
		9'h001: built = {3'h0, des_trk_r, 3'h0, des_sec_r};
		// [R12] keys passed through
		`KEY1_WORD: built = key1_r;
		`KEY2_WORD: built = key2_r;
		default: built = 16'h0000;
	endcase
end

reg [3:0] err_set;
always @*
begin
	err_set = 4'h0;
	// [R16] only in header after lookahead match
	if (state_r == S_HDR && word_tick_i && !is_fmt)
	begin
		// [R14] first two words compared
		if (cnt_r == 9'h000)
		begin
			err_set[`ST_FMT] = (rd_word_i[`CYL_FMT] != des_fmt_r);
			err_set[`ST_HCE] = (rd_word_i[8:0] != des_cyl_r);
		end
		if (cnt_r == 9'h001)
			err_set[`ST_HCE] = (rd_word_i[12:8] != des_trk_r) ||
				(rd_word_i[4:0] != des_sec_r);
		// [R13] CRC checked on read
		if (cnt_r == `HDR_LAST)
			err_set[`ST_CRC] = (rd_word_i != crc_r);
	end
end

wire hdr_fail = hdr_err_r | (|err_set);

// ------------------------------------------------------------
// Sequencer
// ------------------------------------------------------------
reg done_set;
wire go = bus_wr & wb_sel_i[0] & (idx == `REG_CTRL) & wdat[`CTRL_GO] & ~busy &
	(wdat[3:1] != `FN_NONE);

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		state_r <= S_IDLE;
		fn_r <= `FN_NONE;
		cnt_r <= 9'h000;
		crc_r <= `CRC_INIT;
		hdr_err_r <= 1'b0;
		short_r <= 1'b0;
		wr_word_o <= 16'h0000;
		wr_gate_o <= 1'b0;
		data_take_o <= 1'b0;
		xfer_word_o <= 16'h0000;
		xfer_valid_o <= 1'b0;
		done_set <= 1'b0;
	end
	else
	begin
		data_take_o <= 1'b0;
		xfer_valid_o <= 1'b0;
		done_set <= 1'b0;
		case (state_r)
			S_IDLE:
			begin
				// Control writes refused while busy
				if (go)
				begin
					fn_r <= wdat[3:1];
					state_r <= S_SEEK;
				end
			end
			S_SEEK:
			begin
				// [R16] lookahead matches desired sector
				if (sector_start && sec_nxt == des_sec_r)
				begin
					state_r <= S_HDR;
					cnt_r <= 9'h000;
					// [R19] same seed both ways
					crc_r <= `CRC_INIT;
					hdr_err_r <= 1'b0;
					short_r <= 1'b0;
				end
			end
			S_HDR:
			begin
				if (word_tick_i)
				begin
					hdr_err_r <= hdr_fail;
					// [R07] five header words
					if (cnt_r != `HDR_LAST)
					begin
						cnt_r <= cnt_r + 9'h001;
						crc_r <= crc_step(crc_r, is_fmt ? built : rd_word_i);
						if (is_fmt)
						begin
							wr_word_o <= built;
							wr_gate_o <= 1'b1;
						end
						// [R17] header goes to memory
						if (fn_r == `FN_READ_HDR)
						begin
							xfer_word_o <= rd_word_i;
							xfer_valid_o <= 1'b1;
						end
					end
					else
					begin
						cnt_r <= 9'h000;
						// [R13] CRC written, never sent to memory
						if (is_fmt)
							wr_word_o <= crc_r;
						if (hdr_fail && fn_r != `FN_READ_HDR && !is_fmt)
						begin
							state_r <= S_IDLE;
							done_set <= 1'b1;
						end
						else
						begin
							state_r <= S_DATA;
							wr_gate_o <= is_wr;
						end
					end
				end
			end
			S_DATA:
			begin
				if (word_tick_i)
				begin
					cnt_r <= cnt_r + 9'h001;
					if (is_wr)
					begin
						// [R06] zero fill once data runs out
						if (data_valid_i && !short_r)
						begin
							wr_word_o <= data_i;
							data_take_o <= 1'b1;
						end
						else
						begin
							wr_word_o <= 16'h0000;
							short_r <= 1'b1;
						end
					end
					else
					begin
						xfer_word_o <= rd_word_i;
						xfer_valid_o <= 1'b1;
					end
					// [R06] fixed 256-word field
					if (cnt_r == `DATA_LAST)
					begin
						state_r <= S_IDLE;
						done_set <= 1'b1;
					end
				end
				else if (cnt_r == 9'h000 && !is_wr)
					wr_gate_o <= 1'b0;
			end
			default: state_r <= S_IDLE;
		endcase
		if (state_r == S_DATA && word_tick_i && cnt_r == `DATA_LAST)
			wr_gate_o <= 1'b0;
	end
end

// ------------------------------------------------------------
// Registers
// ------------------------------------------------------------
wire [3:0] ev = err_set | {3'h0, done_set};
wire [15:0] cyl_word = {3'h0, des_fmt_r, 3'h0, des_cyl_r};
wire [15:0] st_word = {3'h0, des_trk_r, 3'h0, des_sec_r};
wire [15:0] cyl_new = merge16(cyl_word, wdat, wb_sel_i[1:0]);
wire [15:0] st_new = merge16(st_word, wdat, wb_sel_i[1:0]);
wire [15:0] stat_clr = (bus_wr && idx == `REG_STAT && wb_sel_i[0]) ? wdat : 16'h0000;

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		des_cyl_r <= 9'h000;
		des_fmt_r <= 1'b0;
		des_trk_r <= 5'h00;
		des_sec_r <= 5'h00;
		key1_r <= 16'h0000;
		key2_r <= 16'h0000;
		mask_r <= 4'h0;
		stat_r <= 4'h0;
	end
	else
	begin
		// [R15] sticky error bits, set beats clear
		stat_r <= (stat_r & ~stat_clr[3:0]) | ev;
		// [R03] address fields loaded while idle only
		if (bus_wr && !busy)
		begin
			case (idx)
				`REG_CYL:
				begin
					des_cyl_r <= cyl_new[8:0];
					des_fmt_r <= cyl_new[`CYL_FMT];
				end
				`REG_SECTRK:
				begin
					des_trk_r <= st_new[12:8];
					des_sec_r <= st_new[4:0];
				end
				// [R12] software supplies keys for format
				`REG_KEY1: key1_r <= merge16(key1_r, wdat, wb_sel_i[1:0]);
				`REG_KEY2: key2_r <= merge16(key2_r, wdat, wb_sel_i[1:0]);
				default: ;
			endcase
		end
		if (bus_wr && idx == `REG_MASK && wb_sel_i[0])
			mask_r <= wdat[3:0];
	end
end

// ------------------------------------------------------------
// Read path and interrupt
// ------------------------------------------------------------
reg [15:0] rdat;
always @*
begin
	rdat = 16'h0000;
	// [R01] 16-bit drive registers, upper bits zero
	case (idx)
		`REG_CTRL:
		begin
			rdat[3:1] = fn_r;
			rdat[`CTRL_BUSY] = busy;
		end
		`REG_STAT: rdat[3:0] = stat_r;
		`REG_MASK: rdat[3:0] = mask_r;
		`REG_CYL: rdat = cyl_word;
		`REG_SECTRK: rdat = st_word;
		`REG_KEY1: rdat = key1_r;
		`REG_KEY2: rdat = key2_r;
		`REG_LOOKAHEAD: rdat[10:6] = sec_cnt_r;
		// [R02] drive-generated shared bits only
		`REG_SHARED:
		begin
			rdat[`SH_ERR] = |stat_r[3:1];
			rdat[`SH_READY] = ~busy;
			rdat[4:0] = sec_cnt_r;
		end
		default: rdat = 16'h0000;
	endcase
end

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h00000000;
		irq_o <= 1'b0;
	end
	else
	begin
		// One wait state; unmapped words ack with zero
		wb_ack_o <= bus_req;
		wb_dat_o <= {16'h0000, rdat};
		irq_o <= |(stat_r & mask_r);
	end
end

endmodule

// [common/disk_hdr_map.vh]
// Register map, field layout and format constants of the sector header checker
`ifndef DISK_HDR_MAP_VH
`define DISK_HDR_MAP_VH

// Register word index, taken from wb_adr_i[5:2]
`define REG_CTRL 4'h0
`define REG_STAT 4'h1
`define REG_MASK 4'h2
`define REG_CYL 4'h3
`define REG_SECTRK 4'h4
`define REG_KEY1 4'h5
`define REG_KEY2 4'h6
`define REG_LOOKAHEAD 4'h7
`define REG_SHARED 4'h8

// Functions held in control bits 3:1
`define FN_NONE 3'h0
`define FN_FORMAT 3'h1
`define FN_WRITE 3'h2
`define FN_READ 3'h3
`define FN_READ_HDR 3'h4

// Status bits, also the interrupt sources
`define ST_DONE 0
`define ST_FMT 1
`define ST_HCE 2
`define ST_CRC 3

// Field positions
`define CTRL_GO 0
`define CTRL_BUSY 7
`define CYL_FMT 12
`define SH_ERR 12
`define SH_READY 11
`define LA_LSB 6

// Track format
`define LAST_SECTOR 5'h15
`define HDR_LAST 9'h004
`define KEY1_WORD 9'h002
`define KEY2_WORD 9'h003
`define DATA_LAST 9'h0FF

// Header CRC, applied identically on generate and check
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hFFFF

`endif

// [tb/disk_sector_header_check_checker.sv]
// Bus handshake and medium timing checks
`timescale 1ns/1ps
module disk_sector_header_check_checker
(
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire [31:0] wb_dat_o,
	// Medium and memory
	input wire word_tick_i,
	input wire [15:0] wr_word_o,
	input wire wr_gate_o,
	input wire data_take_o,
	input wire xfer_valid_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_walk: assert property (s_req |=> s_pulse)
		else $error("ack not a single pulse after request");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_ack_drops: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_read_width: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_take_tick: assert property (data_take_o |-> $past(word_tick_i))
		else $error("data taken off a word slot");
	a_xfer_tick: assert property (xfer_valid_o |-> $past(word_tick_i))
		else $error("memory word off a word slot");
	a_word_held: assert property (wr_gate_o && $past(wr_gate_o) && !$past(word_tick_i)
		|-> $stable(wr_word_o))
		else $error("write word changed between slots");
	a_gate_slot: assert property ($changed(wr_gate_o) |-> $past(word_tick_i))
		else $error("write gate moved off a slot");
endmodule
bind disk_sector_header_check disk_sector_header_check_checker checker_i (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .word_tick_i(word_tick_i),
	.wr_word_o(wr_word_o), .wr_gate_o(wr_gate_o), .data_take_o(data_take_o),
	.xfer_valid_o(xfer_valid_o));

// [tb/disk_medium_model.sv]
// Medium and memory side: word slots, stored header, short write data
`timescale 1ns/1ps
module disk_medium_model
#(
	parameter GAP = 3
)
(
	// Clock and index
	input wire clk_i,
	input wire index_i,
	// Toward the drive logic
	output reg word_tick_o = 1'b0,
	output reg [15:0] rd_word_o = 16'h0000,
	output reg [15:0] data_o = 16'h0000,
	output reg data_valid_o = 1'b0
);
	reg [15:0] hdr [0:4];
	integer slot = 0, gap = 0, nvalid = 2;
	always @(posedge clk_i)
	begin
		word_tick_o <= 1'b0;
		gap <= gap + 1;
		if (index_i)
		begin
			slot <= 0;
			gap <= 0;
		end
		else if (gap >= GAP)
		begin
			gap <= 0;
			slot <= slot + 1;
			word_tick_o <= 1'b1;
			rd_word_o <= (slot < 5) ? hdr[slot] : 16'h7000 + slot[15:0];
			// fewer useful words, then the line wanders
			data_valid_o <= slot >= 5 && slot - 5 < nvalid;
			data_o <= (slot - 5 < nvalid) ? 16'hA000 + slot[15:0] - 16'h0005 : ~slot[15:0];
		end
	end
endmodule

// [tb/tb_top.sv]
// Self-checking bench: registers, format, verify reads and header faults
`timescale 1ns/1ps
`include "disk_hdr_map.vh"
module tb_top;
	reg clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	reg index_i = 1'b0, sector_i = 1'b0, tick_d = 1'b0, cap = 1'b0;
	reg [7:0] wb_adr_i = 8'h00;
	reg [31:0] wb_dat_i = 32'h00000000, rd;
	reg [15:0] wq [0:300];
	reg [15:0] h [0:4];
	reg [15:0] xf0, c;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, word_tick_i, data_valid_i, wr_gate_o, data_take_o, xfer_valid_o, irq_o;
	wire [15:0] rd_word_i, data_i, wr_word_o, xfer_word_o;
	integer mismatches = 0, total_checks = 0, wn = 0, xn = 0, i, k, nsec = 0, tk = 0;
	always #20 clk_i = ~clk_i;
	disk_sector_header_check disk_sector_header_check_i (.clk_i(clk_i), .rst_i(rst_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'h3), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.index_i(index_i), .sector_i(sector_i), .word_tick_i(word_tick_i), .rd_word_i(rd_word_i),
		.wr_word_o(wr_word_o), .wr_gate_o(wr_gate_o), .data_i(data_i),
		.data_valid_i(data_valid_i), .data_take_o(data_take_o), .xfer_word_o(xfer_word_o),
		.xfer_valid_o(xfer_valid_o), .irq_o(irq_o));
	// Slots restart at every sector start, so the header follows the pulse
	disk_medium_model disk_medium_model_i (.clk_i(clk_i), .index_i(index_i | sector_i),
		.word_tick_o(word_tick_i), .rd_word_o(rd_word_i), .data_o(data_i),
		.data_valid_o(data_valid_i));
	always @(posedge clk_i)
	begin
		tick_d <= word_tick_i;
		if (data_take_o)
			tk <= tk + 1;
		if (tick_d && cap)
		begin
			wq[wn] <= wr_word_o;
			wn <= wn + 1;
		end
		if (xfer_valid_o)
		begin
			if (xn == 0)
				xf0 <= xfer_word_o;
			xn <= xn + 1;
		end
		// Counts restart with each operation's index pulse
		if (index_i)
		begin
			wn <= 0;
			xn <= 0;
			tk <= 0;
		end
	end
	function [15:0] hdr_crc(input [15:0] s, input [15:0] d);
		integer b;
		hdr_crc = s;
		for (b = 15; b >= 0; b = b - 1)
			hdr_crc = {hdr_crc[14:0], 1'b0} ^ ((hdr_crc[15] ^ d[b]) ? `CRC_POLY : 16'h0000);
	endfunction
	task check(input [31:0] seen, input [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp)
		begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Wait on ack alone; the watchdog bounds a missing answer
	task bus(input we, input [7:0] adr, input [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task pulse_sec;
		@(posedge clk_i);
		sector_i <= 1'b1;
		@(posedge clk_i);
		sector_i <= 1'b0;
	endtask
	task rdc(input [7:0] adr, input [31:0] exp);
		bus(1'b0, adr, 32'h00000000);
		check(rd, exp);
	endtask
	task op(input [2:0] fn, input [31:0] st, input integer xc, input [15:0] x0);
		bus(1'b1, 8'h00, {28'h0000000, fn, 1'b1});
		@(posedge clk_i);
		index_i <= 1'b1;
		@(posedge clk_i);
		index_i <= 1'b0;
		// Armed late so a slot ahead of the index is never captured
		cap <= 1'b1;
		repeat (nsec) pulse_sec;
		bus(1'b1, 8'h0C, 32'h00000000);
		while (irq_o !== 1'b1)
			@(posedge clk_i);
		cap <= 1'b0;
		rdc(8'h04, st);
		check(xn, xc);
		if (xc != 0)
			check(xf0, x0);
		bus(1'b1, 8'h04, 32'h0000000F);
		rdc(8'h04, 32'h00000000);
		check(irq_o, 1'b0);
		rdc(8'h0C, 32'h0000119A);
		$display("Test done: function %0d", fn);
	endtask
	task vcase(input [2:0] fn, input integer w, input [15:0] m, input [31:0] st,
		input integer xc, input [15:0] x0);
		for (k = 0; k < 5; k = k + 1)
			disk_medium_model_i.hdr[k] = h[k] ^ ((k == w) ? m : 16'h0000);
		c = `CRC_INIT;
		for (k = 0; k < 4; k = k + 1)
			c = hdr_crc(c, disk_medium_model_i.hdr[k]);
		if (w < 4)
			disk_medium_model_i.hdr[4] = c;
		op(fn, st, xc, x0);
	endtask
	task stop_test;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Five full-sector operations of some 1100 cycles each and five cut short after the header fit well inside this span
	initial
	begin
		#(40 * 30000);
		mismatches = mismatches + 1;
		stop_test;
	end
	initial
	begin
		h[0] = 16'h119A;
		h[1] = 16'h1200;
		h[2] = 16'h5A3C;
		h[3] = 16'hC3A5;
		h[4] = `CRC_INIT;
		for (i = 0; i < 4; i = i + 1)
			h[4] = hdr_crc(h[4], h[i]);
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(8'h00, 32'h00000000);
		rdc(8'h24, 32'h00000000);
		$display("Test done: reset");
		bus(1'b1, 8'h08, 32'h00000001);
		for (i = 0; i < 4; i = i + 1)
			bus(1'b1, 8'h0C + {i[5:0], 2'b00}, {16'h0000, h[i]});
		op(`FN_FORMAT, 32'h1, 0, 16'h0000);
		check(tk, 2);
		for (i = 0; i < 5; i = i + 1)
			check(wq[i], h[i]);
		check(wq[5], 16'hA000);
		check(wq[6], 16'hA001);
		check(wq[7], 16'h0000);
		check(wq[260], 16'h0000);
		vcase(`FN_READ, 0, 16'h0000, 32'h1, 256, 16'h7005);
		vcase(`FN_READ, 4, 16'h0001, 32'h9, 0, 16'h0000);
		vcase(`FN_READ, 0, 16'h0001, 32'h5, 0, 16'h0000);
		vcase(`FN_READ, 1, 16'h0100, 32'h5, 0, 16'h0000);
		vcase(`FN_READ, 1, 16'h0001, 32'h5, 0, 16'h0000);
		vcase(`FN_READ, 0, 16'h1000, 32'h3, 0, 16'h0000);
		vcase(`FN_READ, 2, 16'hFFFF, 32'h1, 256, 16'h7005);
		vcase(`FN_READ_HDR, 0, 16'h0000, 32'h1, 260, 16'h119A);
		h[1] = 16'h1202;
		bus(1'b1, 8'h10, 32'h00001202);
		nsec = 2;
		vcase(`FN_READ, 0, 16'h0000, 32'h1, 256, 16'h7005);
		rdc(8'h1C, 32'h00000080);
		rdc(8'h20, 32'h00000802);
		repeat (20) pulse_sec;
		rdc(8'h1C, 32'h00000000);
		$display("Test done: sector count");
		stop_test;
	end
endmodule
